// ### flash_device_model.sv
// partner: behavioural page flash with status polls, guard and erase
`timescale 1ns/1ps
module flash_device_model #(
    parameter int WRITE_NS = 3000
) (
    input wire logic                                   cs_n,
    input wire logic                                   rd_n,
    input wire logic                                   wr_n,
    input wire logic [15:0]                            a,
    input wire logic [7:0]                             d,
    input wire flash_host_pkg::cmd_byte_t [5:0]        pre_tab,
    input wire flash_host_pkg::cmd_byte_t [5:0]        off_tab,
    input wire flash_host_pkg::cmd_byte_t [5:0]        er_tab,
    output logic [7:0]                                 q,
    output logic                                       q_oe
);
    logic [7:0]  mem [65536];
    logic [7:0]  pbuf [128];
    bit          hit [128];
    flash_host_pkg::cmd_byte_t seq [$];
    logic        guard = 1'b0, writing = 1'b0, locked = 1'b0, tog = 1'b0, pend = 1'b0;
    logic [15:0] la;
    logic [7:0]  ld;
    realtime     t_fall = 0.0, t_rise = 0.0;
    wire         act_ld = !cs_n && !wr_n && rd_n;
    wire         act_rd = !cs_n && !rd_n;

    initial for (int i = 0; i < 65536; i++) mem[i] = 8'h5A;

    function automatic bit seq_is(input flash_host_pkg::cmd_byte_t [5:0] t, input int n);
        if (seq.size() < n) return 1'b0;
        for (int i = 0; i < n; i++) if (seq[i] !== t[i]) return 1'b0;
        return 1'b1;
    endfunction

    // address taken as the later strobe falls, read strobe high
    always @(posedge act_ld) begin
        la = a;
        t_fall = $realtime;
    end
    // data taken as the first strobe rises, glitches dropped
    always @(negedge act_ld) begin
        if (!writing && !locked && $realtime - t_fall >= 5.0) begin
            seq.push_back({la, d});
            t_rise = $realtime;
            pend = 1'b1;
        end
    end
    // commit once the bus stays quiet for the load timeout
    initial forever begin
        wait (pend);
        while ($realtime - t_rise < 200000.0) #100;
        pend = 1'b0;
        commit();
    end

    task automatic commit();
        int first;
        logic [8:0] pg;
        first = seq_is(pre_tab, 3) ? 3 : 0;
        tog = 1'b0;
        // six-byte sequences from the command table
        if (seq.size() == 6 && (seq_is(off_tab, 6) || seq_is(er_tab, 6))) begin
            ld = 8'hFF;
            writing = 1'b1;
            #(WRITE_NS);
            if (seq_is(er_tab, 6)) for (int i = 0; i < 65536; i++) mem[i] = 8'hFF;
            else guard = 1'b0;
            writing = 1'b0;
        // unguarded write while guarded locks the whole device
        end else if (guard && first == 0) begin
            locked = 1'b1;
            #300000;
            locked = 1'b0;
        // whole page at once, unloaded bytes erased
        end else begin
            for (int i = 0; i < 128; i++) hit[i] = 1'b0;
            for (int i = first; i < seq.size(); i++) begin
                pbuf[seq[i].addr[6:0]] = seq[i].data;
                hit[seq[i].addr[6:0]] = 1'b1;
                pg = seq[i].addr[15:7];
                ld = seq[i].data;
            end
            guard = guard | (first == 3);
            writing = 1'b1;
            #(WRITE_NS);
            for (int i = 0; i < 128; i++) mem[{pg, 7'(i)}] = hit[i] ? pbuf[i] : 8'hFF;
            writing = 1'b0;
        end
        seq.delete();
    endtask

    // each busy read flips the status bit, first read high
    always @(posedge act_rd) if (writing || locked) tog = ~tog;
    // drive only while selected and read, status while busy
    always @* begin
        q_oe = act_rd;
        if (locked) q = tog ? 8'hAA : 8'h55;
        else if (writing) q = {~ld[7], tog, ld[5:0]};
        else q = mem[a];
    end
endmodule

// ### flash_host_pkg.sv
// package: pin timing, command table layout and user-side types for the flash host
package flash_host_pkg;
    localparam int          ADDR_W        = 16;
    localparam int          DATA_W        = 8;
    localparam int          PAGE_BYTES    = 128;
    localparam int          PAGE_LSB      = 7;
    localparam int          CLK_HZ        = 10_000_000;
    // strobe low time, least, in ns (well above the glitch filter)
    localparam int          STROBE_NS     = 200;
    localparam int          STROBE_CYC    = (STROBE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    // spacing between byte loads, longest, in us (inside the byte load window)
    localparam int          LOAD_WIN_US   = 100;
    localparam int          LOAD_WIN_CYC  = LOAD_WIN_US * (CLK_HZ / 1_000_000) / 2;
    // page load timeout, least wait in us, before polling makes sense
    localparam int          LOAD_TMO_US   = 200;
    localparam int          LOAD_TMO_CYC  = LOAD_TMO_US * (CLK_HZ / 1_000_000) + 1;
    // lockout after an unguarded write while guarded, in us
    localparam int          LOCK_US       = 300;
    localparam int          LOCK_CYC      = LOCK_US * (CLK_HZ / 1_000_000);
    // write cycle, typical, in ms; poll gives up after four of them
    localparam int          WRITE_MS      = 5;
    localparam int          POLL_LIMIT    = 4 * WRITE_MS * (CLK_HZ / 1000);
    localparam int          PREAMBLE_LEN  = 3;
    localparam int          SEQ6_LEN      = 6;
    localparam int          CMD_SLOTS     = 6;
    localparam logic [7:0]  ERASED_BYTE   = 8'hFF;
    localparam int          POLL_BIT      = 7;
    localparam int          TOGGLE_BIT    = 6;

    typedef enum logic [1:0] {
        OP_PAGE_WRITE,
        OP_GUARD_OFF,
        OP_CHIP_ERASE
    } op_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } cmd_byte_t;

    typedef struct packed {
        logic              cs_n;
        logic              rd_n;
        logic              wr_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dout;
        logic              doe;
    } pin_out_t;
endpackage

// ### page_flash_write_protect.sv
// host controller that drives the page flash over its byte-wide strobe bus
// What this block does
// - optional preamble, byte loads, then timed commit
// - load one to 128 bytes per page
// - only status polls read during write
// - all bytes in page share A15..A7
// - next load starts within byte window
// - preamble enables guard for every write
// - six-byte sequence disables the guard
// - six-byte sequence erases chip
// - two extra reads confirm completion
`timescale 1ns/1ps
module page_flash_write_protect #(
    parameter int POLL_LIMIT_CYC = flash_host_pkg::POLL_LIMIT,
    parameter int LOCK_WAIT_CYC  = flash_host_pkg::LOCK_CYC
) (
    input  wire logic                             clock,
    input  wire logic                             resetn,
    // user side
    input  wire logic                             start,
    input  wire flash_host_pkg::op_t              op,
    input  wire logic                             use_guard,
    input  wire logic [flash_host_pkg::ADDR_W-1:0] page_addr,
    input  wire logic [7:0]                       byte_count,
    input  wire flash_host_pkg::cmd_byte_t [flash_host_pkg::CMD_SLOTS-1:0] cmd_table,
    output logic                                  data_req,
    output logic [6:0]                            data_index,
    input  wire logic [flash_host_pkg::DATA_W-1:0] data_in,
    output logic                                  busy,
    output logic                                  done,
    output logic                                  timeout_err,
    // device pins
    output logic                                  byte_space_select_n,
    output logic                                  rd_n,
    output logic                                  wr_n,
    output logic [flash_host_pkg::ADDR_W-1:0]     addr,
    output logic [flash_host_pkg::DATA_W-1:0]     data_out,
    output logic                                  data_oe,
    input  wire logic [flash_host_pkg::DATA_W-1:0] data_pin_in
);
    initial begin
        if (POLL_LIMIT_CYC < 1 || LOCK_WAIT_CYC < 1) begin
            $error("page_flash_write_protect: counts must be positive");
        end
    end

    typedef enum {
        ST_IDLE, ST_SETUP, ST_STROBE, ST_GAP, ST_SETTLE, ST_RD, ST_RD_END, ST_LOCK, ST_DONE
    } state_t;

    // =========================================================
    // reset synchroniser
    logic rst_meta_reg;
    logic rst_n_reg;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    // =========================================================
    // sequencing state
    state_t                           state_reg;
    flash_host_pkg::op_t              op_reg;
    logic                             guard_reg;
    logic [flash_host_pkg::ADDR_W-1:0] page_reg;
    logic [7:0]                       count_reg;
    logic [3:0]                       cmd_pos_reg;   // index into command bytes
    logic [7:0]                       byte_pos_reg;  // index into page bytes
    logic [31:0]                      timer_reg;
    logic [31:0]                      poll_cnt_reg;
    logic [7:0]                       last_data_reg;
    logic [flash_host_pkg::ADDR_W-1:0] last_addr_reg;
    logic [7:0]                       prev_rd_reg;
    logic                             have_prev_reg;
    logic [1:0]                       confirm_reg;

    // number of command bytes that precede (or make up) this operation
    function automatic logic [3:0] cmd_len(input flash_host_pkg::op_t o, input logic g);
        unique case (o)
            flash_host_pkg::OP_PAGE_WRITE: cmd_len = g ? 4'(flash_host_pkg::PREAMBLE_LEN) : 4'h0;
            flash_host_pkg::OP_GUARD_OFF,
            flash_host_pkg::OP_CHIP_ERASE: cmd_len = 4'(flash_host_pkg::SEQ6_LEN);
        endcase
    endfunction

    logic       in_cmd;
    logic [3:0] total_cmd;
    assign total_cmd = cmd_len(op_reg, guard_reg);
    assign in_cmd    = cmd_pos_reg < total_cmd;

    // pick the next byte to load
    logic [flash_host_pkg::ADDR_W-1:0] load_addr;
    logic [flash_host_pkg::DATA_W-1:0] load_data;
    always_comb begin
        load_addr = '0;
        load_data = '0;
        if (in_cmd) begin
            load_addr = cmd_table[cmd_pos_reg[2:0]].addr;
            load_data = cmd_table[cmd_pos_reg[2:0]].data;
        end else begin
            load_addr = {page_reg[flash_host_pkg::ADDR_W-1:flash_host_pkg::PAGE_LSB],
                         byte_pos_reg[6:0]};
            load_data = data_in;
        end
    end

    logic last_load;
    assign last_load = in_cmd ? (cmd_pos_reg + 4'h1 == total_cmd) && (op_reg != flash_host_pkg::OP_PAGE_WRITE)
                              : (byte_pos_reg + 8'h01 == count_reg);

    // =========================================================
    // main sequencer
    always_ff @(posedge clock or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            state_reg     <= ST_IDLE;
            op_reg        <= flash_host_pkg::OP_PAGE_WRITE;
            guard_reg     <= 1'b0;
            page_reg      <= '0;
            count_reg     <= 8'h00;
            cmd_pos_reg   <= 4'h0;
            byte_pos_reg  <= 8'h00;
            timer_reg     <= 32'h0;
            poll_cnt_reg  <= 32'h0;
            last_data_reg <= 8'h00;
            last_addr_reg <= '0;
            prev_rd_reg   <= 8'h00;
            have_prev_reg <= 1'b0;
            confirm_reg   <= 2'h0;
            timeout_err   <= 1'b0;
            done          <= 1'b0;
            busy          <= 1'b0;
            data_req      <= 1'b0;
            data_index    <= 7'h00;
        end else begin
            done     <= 1'b0;
            data_req <= 1'b0;
            unique case (state_reg)
                ST_IDLE: begin
                    if (start && (op != flash_host_pkg::OP_PAGE_WRITE ||
                        (byte_count != 8'h00 && byte_count <= 8'(flash_host_pkg::PAGE_BYTES)))) begin
                        op_reg       <= op;
                        guard_reg    <= use_guard;
                        page_reg     <= page_addr;
                        count_reg    <= byte_count;
                        cmd_pos_reg  <= 4'h0;
                        byte_pos_reg <= 8'h00;
                        timeout_err  <= 1'b0;
                        busy         <= 1'b1;
                        data_index   <= 7'h00;
                        data_req     <= 1'b1;
                        state_reg    <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    timer_reg <= 32'h0;
                    state_reg <= ST_STROBE;
                end
                ST_STROBE: begin
                    timer_reg <= timer_reg + 32'h1;
                    // one extra cycle: strobes rise while address and data still stand
                    if (timer_reg >= 32'(flash_host_pkg::STROBE_CYC)) begin
                        last_data_reg <= load_data;
                        last_addr_reg <= load_addr;
                        timer_reg     <= 32'h0;
                        if (last_load) begin
                            state_reg <= ST_SETTLE;
                        end else begin
                            state_reg <= ST_GAP;
                        end
                        if (in_cmd) begin
                            cmd_pos_reg <= cmd_pos_reg + 4'h1;
                        end else begin
                            byte_pos_reg <= byte_pos_reg + 8'h01;
                            data_index   <= 7'(byte_pos_reg + 8'h01);
                            data_req     <= ~last_load;
                        end
                    end
                end
                ST_GAP: begin
                    timer_reg <= timer_reg + 32'h1;
                    if (timer_reg + 32'h1 >= 32'(flash_host_pkg::STROBE_CYC) &&
                        timer_reg < 32'(flash_host_pkg::LOAD_WIN_CYC)) begin
                        timer_reg <= 32'h0;
                        state_reg <= ST_STROBE;
                    end
                end
                ST_SETTLE: begin
                    timer_reg <= timer_reg + 32'h1;
                    if (timer_reg + 32'h1 >= 32'(flash_host_pkg::LOAD_TMO_CYC)) begin
                        timer_reg     <= 32'h0;
                        poll_cnt_reg  <= 32'h0;
                        have_prev_reg <= 1'b0;
                        confirm_reg   <= 2'h0;
                        state_reg     <= ST_RD;
                    end
                end
                ST_RD: begin
                    timer_reg    <= timer_reg + 32'h1;
                    poll_cnt_reg <= poll_cnt_reg + 32'h1;
                    // sampled at the edge that raises the read strobe
                    if (timer_reg >= 32'(flash_host_pkg::STROBE_CYC)) begin
                        timer_reg   <= 32'h0;
                        prev_rd_reg <= data_pin_in;
                        have_prev_reg <= 1'b1;
                        state_reg   <= ST_RD_END;
                        if (have_prev_reg &&
                            data_pin_in[flash_host_pkg::TOGGLE_BIT] ==
                                prev_rd_reg[flash_host_pkg::TOGGLE_BIT] &&
                            (op_reg != flash_host_pkg::OP_PAGE_WRITE ||
                             data_pin_in[flash_host_pkg::POLL_BIT] ==
                                last_data_reg[flash_host_pkg::POLL_BIT])) begin
                            confirm_reg <= confirm_reg + 2'h1;
                        end else begin
                            confirm_reg <= 2'h0;
                        end
                    end
                end
                ST_RD_END: begin
                    poll_cnt_reg <= poll_cnt_reg + 32'h1;
                    if (confirm_reg == 2'h2) begin
                        state_reg <= ST_DONE;
                    end else if (poll_cnt_reg >= 32'(POLL_LIMIT_CYC)) begin
                        timeout_err <= 1'b1;
                        timer_reg   <= 32'h0;
                        state_reg   <= ST_LOCK;
                    end else begin
                        state_reg <= ST_RD;
                    end
                end
                ST_LOCK: begin
                    timer_reg <= timer_reg + 32'h1;
                    if (timer_reg + 32'h1 >= 32'(LOCK_WAIT_CYC)) begin
                        state_reg <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    busy      <= 1'b0;
                    done      <= 1'b1;
                    state_reg <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // =========================================================
    // pin drivers, all registered
    flash_host_pkg::pin_out_t pin_next;
    always_comb begin
        pin_next      = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: addr, dout: data_out, doe: 1'b0};
        unique case (state_reg)
            ST_SETUP, ST_GAP: begin
                pin_next.addr = load_addr;
                pin_next.dout = load_data;
                pin_next.doe  = 1'b1;
            end
            ST_STROBE: begin
                // read strobe stays high on writes
                pin_next.cs_n = 1'b0;
                pin_next.wr_n = 1'b0;
                pin_next.addr = load_addr;
                pin_next.dout = load_data;
                pin_next.doe  = 1'b1;
                if (timer_reg >= 32'(flash_host_pkg::STROBE_CYC)) begin
                    pin_next.cs_n = 1'b1;
                    pin_next.wr_n = 1'b1;
                end
            end
            ST_RD: begin
                pin_next.addr = last_addr_reg;
                pin_next.cs_n = 1'b0;
                pin_next.rd_n = 1'b0;
                if (timer_reg >= 32'(flash_host_pkg::STROBE_CYC)) begin
                    pin_next.cs_n = 1'b1;
                    pin_next.rd_n = 1'b1;
                end
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            byte_space_select_n <= 1'b1;
            rd_n                <= 1'b1;
            wr_n                <= 1'b1;
            addr                <= '0;
            data_out            <= '0;
            data_oe             <= 1'b0;
        end else begin
            byte_space_select_n <= pin_next.cs_n;
            rd_n                <= pin_next.rd_n;
            wr_n                <= pin_next.wr_n;
            addr                <= pin_next.addr;
            data_out            <= pin_next.dout;
            data_oe             <= pin_next.doe;
        end
    end
endmodule

// ### page_flash_write_protect_sva.sv
// checker: pin protocol and user handshake assertions for the flash host controller
`timescale 1ns/1ps
module page_flash_write_protect_sva #(
    parameter int POLL_LIMIT_CYC = 50,
    parameter int LOCK_WAIT_CYC  = 10
) (
    input wire logic                    clock,
    input wire logic                    resetn,
    input wire logic                    start,
    input wire flash_host_pkg::op_t     op,
    input wire logic                    data_req,
    input wire logic [6:0]              data_index,
    input wire logic                    busy,
    input wire logic                    done,
    input wire logic                    timeout_err,
    input wire logic                    byte_space_select_n,
    input wire logic                    rd_n,
    input wire logic                    wr_n,
    input wire logic [15:0]             addr,
    input wire logic [7:0]              data_out,
    input wire logic                    data_oe
);
    logic [15:0] quiet_cnt;

    // ====================================================
    // quiet time: cycles since the write strobe was last low in a job
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            quiet_cnt <= 16'h0000;
        end else if (!busy || !wr_n) begin
            quiet_cnt <= 16'h0000;
        end else if (quiet_cnt != 16'hFFFF) begin
            quiet_cnt <= quiet_cnt + 16'h0001;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    // ====================================================
    // assertions
    AST_IDLE_AFTER_RESET: assert property ($rose(resetn) |-> byte_space_select_n && rd_n && wr_n && !data_oe)
        else $error("pins not idle after reset");
    AST_NO_DRIVE_ON_READ: assert property (!rd_n |-> !data_oe && !byte_space_select_n)
        else $error("host drives data during a read");
    AST_WRITE_INHIBIT: assert property (!wr_n |-> rd_n && !byte_space_select_n && data_oe)
        else $error("write strobe without select or with read low");
    AST_STROBE_WIDTH: assert property ($fell(wr_n) |-> !wr_n [*2])
        else $error("write strobe too short");
    AST_LOAD_STABLE: assert property (!wr_n |-> $stable(addr) && $stable(data_out))
        else $error("address or data moved under the strobe");
    AST_BYTE_SPACING: assert property ($fell(wr_n) |-> quiet_cnt <= 16'd1000)
        else $error("byte load gap too long");
    AST_QUIET_BEFORE_POLL: assert property ($fell(rd_n) |-> quiet_cnt >= 16'd2000)
        else $error("status read before load timeout");
    AST_ERASE_STARTS: assert property (start && !busy && op == flash_host_pkg::OP_CHIP_ERASE
        |-> ##[1:2] (data_req && data_index == 7'h00))
        else $error("erase did not begin with slot zero");
    AST_DONE_PULSE: assert property (done |=> !done && !busy)
        else $error("done not a single pulse ending busy");
    AST_FLAG_CLEARED: assert property ($rose(busy) |-> ##[0:1] !timeout_err)
        else $error("timeout flag not cleared at start");

    cover property (done && !timeout_err);
    cover property ($rose(timeout_err));
    cover property ($fell(rd_n));
endmodule

bind page_flash_write_protect page_flash_write_protect_sva #(
    .POLL_LIMIT_CYC(POLL_LIMIT_CYC),
    .LOCK_WAIT_CYC (LOCK_WAIT_CYC)
) u_sva (
    .clock(clock), .resetn(resetn), .start(start), .op(op), .data_req(data_req),
    .data_index(data_index), .busy(busy), .done(done), .timeout_err(timeout_err),
    .byte_space_select_n(byte_space_select_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
    .data_out(data_out), .data_oe(data_oe)
);

// ### testbench.sv
// testbench: page writes, guard on and off, lockout, erase, refused starts
`timescale 1ns/1ps
module testbench;
    logic clock, resetn, start, use_guard, data_req, busy, done, timeout_err;
    logic sel_n, rd_n, wr_n, data_oe, q_oe;
    logic [15:0] page_addr, addr;
    logic [7:0]  byte_count, fill, data_in, bus, bus_last, data_out, q;
    logic [6:0]  data_index;
    logic [7:0]  bad [2] = '{8'd0, 8'd129};
    flash_host_pkg::op_t op;
    flash_host_pkg::cmd_byte_t [5:0] cmd_table, pre_tab, off_tab, er_tab;
    int errors, checks_done;

    // user data and the shared data line, floating to the inverse value
    assign data_in = {1'b0, data_index} + fill;
    assign bus = data_oe ? data_out : (q_oe ? q : ~bus_last);
    always @(posedge clock) if (data_oe || q_oe) bus_last <= bus;

    page_flash_write_protect #(.POLL_LIMIT_CYC(400), .LOCK_WAIT_CYC(3000)) uut (
        .clock(clock), .resetn(resetn), .start(start), .op(op), .use_guard(use_guard),
        .page_addr(page_addr), .byte_count(byte_count), .cmd_table(cmd_table),
        .data_req(data_req), .data_index(data_index), .data_in(data_in), .busy(busy),
        .done(done), .timeout_err(timeout_err), .byte_space_select_n(sel_n),
        .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .data_out(data_out), .data_oe(data_oe),
        .data_pin_in(bus)
    );
    flash_device_model dev (
        .cs_n(sel_n), .rd_n(rd_n), .wr_n(wr_n), .a(addr), .d(bus), .pre_tab(pre_tab),
        .off_tab(off_tab), .er_tab(er_tab), .q(q), .q_oe(q_oe)
    );

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic run_op(input flash_host_pkg::op_t o, input logic g, input logic [15:0] pa,
                          input logic [7:0] n, input flash_host_pkg::cmd_byte_t [5:0] t);
        int k;
        @(posedge clock);
        #1;
        op = o;
        use_guard = g;
        page_addr = pa;
        byte_count = n;
        cmd_table = t;
        start = 1'b1;
        @(posedge clock);
        #1;
        start = 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 40000) begin
            @(posedge clock);
            #1;
            k++;
        end
        chk(16'(k < 40000), 16'h0001);
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clock);
        errors++;
        close_out();
    end

    initial begin
        errors = 0;
        checks_done = 0;
        resetn = 1'b0;
        start = 1'b0;
        op = flash_host_pkg::OP_PAGE_WRITE;
        use_guard = 1'b0;
        page_addr = 16'h0000;
        byte_count = 8'h01;
        fill = 8'h00;
        bus_last = 8'h00;
        for (int i = 0; i < 6; i++) begin
            pre_tab[i] = {16'h1500 + 16'(i), 8'hC0 + 8'(i)};
            off_tab[i] = {16'h2A00 + 16'(i), 8'hD0 + 8'(i)};
            er_tab[i] = {16'h3F00 + 16'(i), 8'hE0 + 8'(i)};
        end
        cmd_table = pre_tab;
        repeat (8) @(posedge clock);
        #1 resetn = 1'b1;
        repeat (3) @(posedge clock);
        fill = 8'h10;
        run_op(flash_host_pkg::OP_PAGE_WRITE, 1'b0, 16'h0280, 8'd3, pre_tab);
        chk(dev.mem[16'h0280], 8'h10);
        chk(dev.mem[16'h0282], 8'h12);
        chk(dev.mem[16'h0283], 8'hFF);
        chk(dev.mem[16'h0300], 8'h5A);
        $display("test plain_page done");
        fill = 8'h40;
        run_op(flash_host_pkg::OP_PAGE_WRITE, 1'b1, 16'h1000, 8'd128, pre_tab);
        chk(dev.mem[16'h107F], 8'hBF);
        chk(dev.guard, 1'b1);
        chk(dev.mem[16'h1500], 8'h5A);
        $display("test guarded_full_page done");
        fill = 8'h20;
        run_op(flash_host_pkg::OP_PAGE_WRITE, 1'b0, 16'h2000, 8'd2, pre_tab);
        chk(timeout_err, 1'b1);
        chk(dev.mem[16'h2000], 8'h5A);
        $display("test lockout done");
        run_op(flash_host_pkg::OP_GUARD_OFF, 1'b0, 16'h0000, 8'd1, off_tab);
        chk(dev.guard, 1'b0);
        chk(timeout_err, 1'b0);
        fill = 8'h77;
        run_op(flash_host_pkg::OP_PAGE_WRITE, 1'b0, 16'h3000, 8'd1, pre_tab);
        chk(dev.mem[16'h3000], 8'h77);
        chk(dev.mem[16'h3001], 8'hFF);
        $display("test guard_off done");
        run_op(flash_host_pkg::OP_CHIP_ERASE, 1'b0, 16'h0000, 8'd1, er_tab);
        chk(dev.mem[16'h1000], 8'hFF);
        chk(dev.mem[16'hFFFF], 8'hFF);
        $display("test erase done");
        foreach (bad[i]) begin
            @(posedge clock);
            #1;
            op = flash_host_pkg::OP_PAGE_WRITE;
            byte_count = bad[i];
            start = 1'b1;
            @(posedge clock);
            #1;
            start = 1'b0;
            repeat (3) @(posedge clock);
            #1 chk(busy, 1'b0);
        end
        $display("test refused_counts done");
        close_out();
    end
endmodule
